// File: ccg_defines.vh
`ifndef CCG_DEFINES_VH
`define CCG_DEFINES_VH
// register indices (byte address is four times the index)
`define CCG_IDX_VREG_TRIM   8'h01
`define CCG_IDX_SYNTH       8'h05
`define CCG_IDX_REFDIV      8'h06
`define CCG_IDX_POSTDIV     8'h07
`define CCG_IDX_CLKSEL      8'h09
`define CCG_IDX_PLLCTL      8'h0A
`define CCG_IDX_FLAGS       8'h0C
`define CCG_IDX_IRCTRIM_HI  8'h18
`define CCG_IDX_IRCTRIM_LO  8'h19
`define CCG_IDX_OSCCTL      8'h1A
`define CCG_IDX_GUARD       8'h1B
`define CCG_IDX_OSCCTL2     8'h1C
// guard unlock key
`define CCG_GUARD_KEY       8'h26
// reset values
`define CCG_RST_SYNTH       8'h18
`define CCG_RST_REFDIV      8'h00
`define CCG_RST_POSTDIV     8'h03
`define CCG_RST_CLKSEL      8'h80
`define CCG_RST_PLLCTL      8'h00
`define CCG_RST_IRCTRIM_HI  8'h00
`define CCG_RST_IRCTRIM_LO  8'h00
`define CCG_RST_OSCCTL      8'h00
`define CCG_RST_OSCCTL2     8'h00
`define CCG_RST_TRIM_POR    8'h00
// field positions
`define CCG_CLKSEL_PLLSEL   7
`define CCG_OSC_ENABLE      7
`define CCG_FLAG_LOCK       3
`define CCG_FLAG_OSC_STARTED_FLAG      0
`define CCG_TRIM_W          4
// reference frequencies in kHz
`define CCG_VCO_RST_KHZ     50000
`define CCG_IRC_KHZ         1000
`endif

// File: ccg_clock_mode_guard.v
// The Wishbone slave port was left to the implementer.
`include "ccg_defines.vh"

module ccg_clock_mode_guard #(
   parameter TRIM_W = `CCG_TRIM_W
) (
   // clock and resets
   input  wire        clock,
   input  wire        resetn,
   input  wire        por_resetn,
   // wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // chip status
   input  wire        special_mode,
   input  wire [TRIM_W-1:0] flash_trim,
   input  wire        osc_started_flag,
   input  wire        pll_lock,
   // clock controls to the analog side
   output reg         pll_internal_ref_mode,
   output reg         pll_external_ref_mode,
   output reg         pll_bypass_osc_mode,
   output reg         pll_enable,
   output reg         internal_ref_osc_enable,
   output reg         osc_enable_bit,
   output reg  [7:0]  synth_multiplier,
   output reg  [3:0]  ref_divider_field,
   output reg  [4:0]  post_divider,
   output reg  [TRIM_W-1:0] regulator_trim
);

   // word index taken from the byte address
   // widened to the index constants so case items match in width
   wire [7:0] idx = {2'b00, wb_adr_i[7:2]};
   wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr  = req & wb_we_i & wb_sel_i[0];
   wire [7:0] wd  = wb_dat_i[7:0];

   // clock configuration registers
   reg [7:0] synth_q;
   reg [7:0] refdiv_q;
   reg [7:0] postdiv_q;
   reg [7:0] clksel_q;
   reg [7:0] pllctl_q;
   reg [7:0] irc_hi_q;
   reg [7:0] irc_lo_q;
   reg [7:0] oscctl_q;
   reg [7:0] oscctl2_q;
   reg       guard_q;
   reg [TRIM_W-1:0] trim_q;
   reg       trim_load_q;

   wire cfg_wr = wr & ~guard_q;

   // reset values select internal pll mode
   // multiplier and dividers reset for 50 MHz vco
   // post divider resets to divide by four
   // blocked writes leave contents as they are
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         synth_q   <= `CCG_RST_SYNTH;
         refdiv_q  <= `CCG_RST_REFDIV;
         postdiv_q <= `CCG_RST_POSTDIV;
         clksel_q  <= `CCG_RST_CLKSEL;
         pllctl_q  <= `CCG_RST_PLLCTL;
         irc_hi_q  <= `CCG_RST_IRCTRIM_HI;
         irc_lo_q  <= `CCG_RST_IRCTRIM_LO;
         oscctl_q  <= `CCG_RST_OSCCTL;
         oscctl2_q <= `CCG_RST_OSCCTL2;
      end else if (cfg_wr) begin
         case (idx)
            `CCG_IDX_SYNTH:      synth_q   <= wd;
            `CCG_IDX_REFDIV:     refdiv_q  <= wd;
            `CCG_IDX_POSTDIV:    postdiv_q <= wd;
            `CCG_IDX_CLKSEL:     clksel_q  <= wd;
            `CCG_IDX_PLLCTL:     pllctl_q  <= wd;
            `CCG_IDX_IRCTRIM_HI: irc_hi_q  <= wd;
            `CCG_IDX_IRCTRIM_LO: irc_lo_q  <= wd;
            `CCG_IDX_OSCCTL:     oscctl_q  <= wd;
            `CCG_IDX_OSCCTL2:    oscctl2_q <= wd;
            default: ;
         endcase
      end
   end

   // guard flag resets cleared so boot code can program the clocks
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         guard_q <= 1'b0;
      end else if (wr && idx == `CCG_IDX_GUARD) begin
         guard_q <= (wd != `CCG_GUARD_KEY);
      end
   end

   // trim_q only cleared by power-on reset; system reset
   // just arms a reload from flash once it is released
   always @(posedge clock or negedge por_resetn) begin
      if (!por_resetn) begin
         trim_q <= {TRIM_W{1'b0}};
      end else if (trim_load_q) begin
         trim_q <= flash_trim;
      end else if (wr && idx == `CCG_IDX_VREG_TRIM && special_mode) begin
         trim_q <= wd[TRIM_W-1:0];
      end
   end

   // one-cycle load strobe in the first clock after system reset
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         trim_load_q <= 1'b1;
      end else begin
         trim_load_q <= 1'b0;
      end
   end

   // read multiplexer
   reg [7:0] rd;
   always @* begin
      rd = 8'h00;
      case (idx)
         `CCG_IDX_VREG_TRIM:  rd = {{(8-TRIM_W){1'b0}}, trim_q};
         `CCG_IDX_SYNTH:      rd = synth_q;
         `CCG_IDX_REFDIV:     rd = refdiv_q;
         `CCG_IDX_POSTDIV:    rd = postdiv_q;
         `CCG_IDX_CLKSEL:     rd = clksel_q;
         `CCG_IDX_PLLCTL:     rd = pllctl_q;
         // start-up and lock flags for software polling
         `CCG_IDX_FLAGS:      rd = {4'h0, pll_lock, 2'b00, osc_started_flag};
         `CCG_IDX_IRCTRIM_HI: rd = irc_hi_q;
         `CCG_IDX_IRCTRIM_LO: rd = irc_lo_q;
         `CCG_IDX_OSCCTL:     rd = oscctl_q;
         `CCG_IDX_GUARD:      rd = {7'h00, guard_q};
         `CCG_IDX_OSCCTL2:    rd = oscctl2_q;
         default:             rd = 8'h00;
      endcase
   end

   // bus answer one cycle after the request; unmapped reads give zero
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h000000, rd} : 32'h00000000;
      end
   end

   // mode decode from clock select and oscillator enable
   wire pll_sel = clksel_q[`CCG_CLKSEL_PLLSEL];
   wire osc_on  = oscctl_q[`CCG_OSC_ENABLE];

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pll_internal_ref_mode   <= 1'b1;
         pll_external_ref_mode   <= 1'b0;
         pll_bypass_osc_mode     <= 1'b0;
         pll_enable              <= 1'b1;
         internal_ref_osc_enable <= 1'b1;
         osc_enable_bit          <= 1'b0;
         synth_multiplier        <= `CCG_RST_SYNTH;
         ref_divider_field       <= 4'h0;
         post_divider            <= 5'h03;
         regulator_trim          <= {TRIM_W{1'b0}};
      end else begin
         // internal reference while oscillator is off
         pll_internal_ref_mode <= pll_sel & ~osc_on;
         // external pll mode once oscillator enabled
         // and only after start-up and lock
         pll_external_ref_mode <= pll_sel & osc_on & osc_started_flag
                                  & pll_lock;
         pll_bypass_osc_mode   <= ~pll_sel & osc_on;
         // pll and internal oscillator always run
         pll_enable              <= 1'b1;
         internal_ref_osc_enable <= 1'b1;
         osc_enable_bit          <= osc_on;
         synth_multiplier        <= synth_q;
         ref_divider_field       <= refdiv_q[3:0];
         // bus clock is the pll output divided by the post divider
         post_divider            <= postdiv_q[4:0];
         regulator_trim          <= trim_q;
      end
   end

endmodule

// File: ccg_checker.sv
module ccg_checker #(parameter int TRIM_W = 4) (
   // watched ports
   input wire logic clock, resetn, por_resetn, wb_cyc_i, wb_stb_i, wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o, special_mode, osc_started_flag, pll_lock,
   input wire logic pll_internal_ref_mode, pll_external_ref_mode,
   input wire logic pll_bypass_osc_mode, pll_enable, internal_ref_osc_enable,
   input wire logic [7:0] synth_multiplier,
   input wire logic [4:0] post_divider,
   input wire logic [TRIM_W-1:0] regulator_trim
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("request not acknowledged");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_reset_state: assert property ($rose(resetn) |-> pll_internal_ref_mode
      && post_divider == 5'h03 && synth_multiplier == 8'h18)
      else $error("wrong clock setup after reset");
   a_run_clocks: assert property (pll_enable && internal_ref_osc_enable)
      else $error("pll or internal oscillator stopped");
   a_mode_single: assert property ($onehot0({pll_internal_ref_mode,
      pll_external_ref_mode, pll_bypass_osc_mode}))
      else $error("several clock modes at once");
   a_ext_locked: assert property (pll_external_ref_mode |->
      $past(osc_started_flag) && $past(pll_lock))
      else $error("external mode without lock");
   // flash load and power-on clear are the only other trim sources
   a_trim_special: assert property ($changed(regulator_trim) && por_resetn
      && $past(por_resetn) && $past(por_resetn, 2) && $past(resetn, 3)
      |-> $past(special_mode) || $past(special_mode, 2))
      else $error("trim changed outside special mode");
   a_synth_cause: assert property ($changed(synth_multiplier) |->
      $past(wb_we_i && wb_adr_i[7:2] == 6'h05)
      || $past(wb_we_i && wb_adr_i[7:2] == 6'h05, 2))
      else $error("multiplier changed without a write");
   a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule
bind ccg_clock_mode_guard ccg_checker #(.TRIM_W(TRIM_W)) u_chk (.clock,
   .resetn, .por_resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .special_mode, .osc_started_flag, .pll_lock,
   .pll_internal_ref_mode, .pll_external_ref_mode, .pll_bypass_osc_mode,
   .pll_enable, .internal_ref_osc_enable, .synth_multiplier, .post_divider,
   .regulator_trim);

// File: test_clock_mode_and_config_guard.sv
module test_clock_mode_and_config_guard;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, resetn = 0, por_resetn = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic wb_we_i = 0, special_mode = 0, osc_started_flag = 0, pll_lock = 0;
   logic [7:0] wb_adr_i = 0, synth_multiplier, q, d;
   logic [3:0] wb_sel_i = 4'hF, flash_trim = 0, ref_divider_field;
   logic [3:0] regulator_trim;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic [4:0] post_divider;
   logic wb_ack_o, pll_internal_ref_mode, pll_external_ref_mode, osc_enable_bit;
   logic pll_bypass_osc_mode, pll_enable, internal_ref_osc_enable;
   logic [5:0] idx [8] = '{6'h05, 6'h06, 6'h09, 6'h0A, 6'h18, 6'h19, 6'h1A,
      6'h1C};
   logic [7:0] rst [8] = '{8'h18, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00};
   int err_total = 0, checks = 0;
   ccg_clock_mode_guard dut (.clock, .resetn, .por_resetn, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .special_mode, .flash_trim, .osc_started_flag, .pll_lock,
      .pll_internal_ref_mode, .pll_external_ref_mode, .pll_bypass_osc_mode,
      .pll_enable, .internal_ref_osc_enable, .osc_enable_bit,
      .synth_multiplier, .ref_divider_field, .post_divider, .regulator_trim);
   // 100 MHz clock
   always #5 clock = ~clock;
   task conclude;
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // any write other than the key arms the guard
   function logic [7:0] guard_exp(input logic [7:0] v);
      return {7'h0, v != 8'h26};
   endfunction
   // one classic cycle; entered just after a rising edge
   task bus(input logic w, input logic [5:0] i, input logic [7:0] v);
      int n;
      n = 0;
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
      wb_adr_i <= {i, 2'b00}; wb_dat_i <= {24'h0, v};
      do begin @(posedge clock); #1; n++; end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk(0, 1);
      q = wb_dat_o[7:0];
      @(posedge clock);
      wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
      @(posedge clock);
   endtask
   // watchdog sized well above the sequence length
   initial begin #100000; err_total++; conclude; end
   // main sequence
   initial begin
      void'($urandom(35090));
      flash_trim = $urandom;
      repeat (10) @(posedge clock);
      resetn <= 1; por_resetn <= 1;
      repeat (3) @(posedge clock);
      chk(pll_internal_ref_mode, 1);
      chk(synth_multiplier, 8'h18);
      chk(post_divider, 5'h03);
      chk(pll_enable & internal_ref_osc_enable, 1);
      chk(regulator_trim, flash_trim);
      bus(0, 6'h09, 0); chk(q, 8'h80);
      for (int k = 0; k < 8; k++) begin
         d = $urandom | 8'h01;
         bus(1, 6'h1B, d); bus(0, 6'h1B, 0); chk(q, guard_exp(d));
         bus(1, idx[k], $urandom); bus(0, idx[k], 0); chk(q, rst[k]);
      end
      bus(1, 6'h1B, 8'h26); bus(0, 6'h1B, 0); chk(q, 0);
      d = $urandom;
      bus(1, 6'h05, d); chk(synth_multiplier, d);
      bus(1, 6'h06, d); chk(ref_divider_field, d[3:0]);
      bus(1, 6'h09, 8'h80); bus(1, 6'h1A, 8'h80);
      chk(osc_enable_bit, 1);
      chk(pll_external_ref_mode, 0);
      osc_started_flag <= 1; pll_lock <= 1;
      repeat (3) @(posedge clock);
      chk(pll_external_ref_mode, 1);
      bus(0, 6'h0C, 0); chk(q, 8'h09);
      bus(1, 6'h09, 8'h00); chk(pll_bypass_osc_mode, 1);
      bus(1, 6'h01, d); bus(0, 6'h01, 0); chk(q, flash_trim);
      special_mode <= 1;
      bus(1, 6'h01, d); bus(0, 6'h01, 0); chk(q, d[3:0]);
      special_mode <= 0; por_resetn <= 0;
      @(posedge clock); por_resetn <= 1;
      repeat (2) @(posedge clock);
      chk(regulator_trim, 0);
      bus(0, 6'h3F, 0); chk(q, 0);
      conclude;
   end
endmodule
